// ==== verilog/ldp_params.svh ====
// constants for the led dimming pwm control block
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH
`define LDP_CHANNELS       4
`define LDP_DUTY_W         10
`define LDP_ANA_W          8
`define LDP_CNT_MAX        10'h3FF
`define LDP_CNT_ZERO       10'h000
`define LDP_QUARTER        10'h100
`define LDP_FREQ_SEL_W     6
`define LDP_PRESC_W        16
`define LDP_MEAS_W         20
`define LDP_VOLT_W         8
`define LDP_ANA_LOW        8'h0F
`define LDP_ANA_HIGH       8'h99
`define LDP_FRAME_MIN_HZ   30
`define LDP_FRAME_MAX_HZ   300
`define LDP_CLK_HZ         20000000
`define LDP_FRAME_MAX_CYC  (`LDP_CLK_HZ / `LDP_FRAME_MIN_HZ)
`define LDP_FRAME_MIN_CYC  (`LDP_CLK_HZ / `LDP_FRAME_MAX_HZ)
`endif

// ==== verilog/ldp_pkg.sv ====
// types for the led dimming pwm control block
package ldp_pkg;
  typedef enum logic [1:0] {
    ldp_direct,
    ldp_free_run,
    ldp_frame_sync
  } ldp_mode_t;
endpackage

// ==== verilog/ldp_sync.sv ====
// two-flop synchroniser for a pin input
module ldp_sync (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      synced
);
  logic stage1;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      synced <= 1'b0;
    end else begin
      stage1 <= pin;
      synced <= stage1;
    end
  end
endmodule

// ==== verilog/ldp_channel.sv ====
// one channel compare window with phase offset
`include "ldp_params.svh"
module ldp_channel (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic [`LDP_DUTY_W-1:0]  period_count,
  input  wire logic [`LDP_DUTY_W-1:0]  offset,
  input  wire logic [`LDP_DUTY_W:0]    duty,
  output logic                         gate_on
);
  // modulo arithmetic wraps the window across the period end
  wire logic [`LDP_DUTY_W-1:0] local_count = period_count - offset;
  wire logic                   next_on = {1'b0, local_count} < duty;
  always_ff @(posedge core_clk) begin
    if (reset) gate_on <= 1'b0;
    else gate_on <= next_on;
  end
endmodule

// ==== verilog/ldp_dimming.sv ====
// dimming control: duty decode, pwm regeneration, phase shift, level select
`include "ldp_params.svh"
module ldp_dimming (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         direct_mode_tie,
  input  wire logic                         frame_sync_enable,
  input  wire logic                         phase_shift_enable,
  input  wire logic                         current_level_select,
  input  wire logic                         dimming_pwm_input,
  input  wire logic                         analog_dimming_enable,
  input  wire logic [`LDP_ANA_W-1:0]        analog_dimming_input,
  input  wire logic                         frame_sync_input,
  input  wire logic [`LDP_FREQ_SEL_W-1:0]   freq_select,
  input  wire logic [`LDP_PRESC_W-1:0]      free_run_divider,
  input  wire logic [`LDP_CHANNELS*`LDP_VOLT_W-1:0] led_channel_voltage,
  output logic [`LDP_CHANNELS-1:0]          led_channel_enable,
  output logic                              use_second_current_set,
  output logic [`LDP_VOLT_W-1:0]            headroom_min_voltage,
  output logic [1:0]                        headroom_min_channel,
  output logic                              frame_locked,
  output logic [`LDP_DUTY_W:0]              active_duty
);
  ldp_pkg::ldp_mode_t mode;

  logic pwm_s, tie_s, frame_s, frame_d, pwm_d;
  ldp_sync u_sync_pwm (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (dimming_pwm_input),
    .synced   (pwm_s)
  );
  ldp_sync u_sync_tie (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (direct_mode_tie),
    .synced   (tie_s)
  );
  ldp_sync u_sync_frame (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (frame_sync_input),
    .synced   (frame_s)
  );

  // mode selection
  wire logic is_direct = tie_s;
  always_comb begin
    if (is_direct) mode = ldp_pkg::ldp_direct;
    else if (frame_sync_enable) mode = ldp_pkg::ldp_frame_sync;
    else mode = ldp_pkg::ldp_free_run;
  end

  // input duty measurement over one input period, rising edge to rising edge
  logic [`LDP_MEAS_W-1:0] meas_total, meas_high;
  logic [`LDP_DUTY_W:0]   pwm_duty;
  logic                   meas_seen;
  wire logic pwm_rise = pwm_s & ~pwm_d;
  // a product keeps full precision before the divide
  wire logic [`LDP_MEAS_W+`LDP_DUTY_W:0] meas_scaled =
    {{(`LDP_DUTY_W+1){1'b0}}, meas_high} << `LDP_DUTY_W;
  wire logic [`LDP_MEAS_W+`LDP_DUTY_W:0] meas_div =
    meas_scaled / {{(`LDP_DUTY_W+1){1'b0}}, meas_total};
  wire logic meas_sat = &meas_total;
  // held high input never rises: when the count reaches all ones, clear the counters and call it full
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwm_d      <= 1'b0;
      meas_total <= '0;
      meas_high  <= '0;
      meas_seen  <= 1'b0;
      pwm_duty   <= '0;
    end else begin
      pwm_d <= pwm_s;
      if (pwm_rise) begin
        meas_total <= {{(`LDP_MEAS_W-1){1'b0}}, 1'b1};
        meas_high  <= {{(`LDP_MEAS_W-1){1'b0}}, 1'b1};
        meas_seen  <= 1'b1;
        if (meas_seen && meas_total != '0)
          pwm_duty <= meas_div[`LDP_DUTY_W:0];
      end else if (meas_sat) begin
        pwm_duty  <= pwm_s ? {1'b1, `LDP_CNT_ZERO} : '0;
        meas_seen <= 1'b0;
        meas_total <= '0;
        meas_high  <= '0;
      end else begin
        meas_total <= meas_total + 1'b1;
        if (pwm_s) meas_high <= meas_high + 1'b1;
      end
    end
  end

  // analog level: code span maps linearly onto 0..256, so half span is 128
  wire logic [`LDP_ANA_W-1:0] ana_span = `LDP_ANA_HIGH - `LDP_ANA_LOW;
  wire logic [`LDP_ANA_W-1:0] ana_off =
    (analog_dimming_input <= `LDP_ANA_LOW) ? '0 :
    (analog_dimming_input >= `LDP_ANA_HIGH) ? ana_span :
    analog_dimming_input - `LDP_ANA_LOW;
  wire logic [15:0] ana_scaled = {ana_off, 8'h00};
  wire logic [`LDP_ANA_W:0] ana_level = (ana_off == ana_span) ? 9'h100 :
    9'(ana_scaled / {8'h00, ana_span});
  wire logic [19:0] prod = {9'h000, pwm_duty} * {11'h000, ana_level};
  wire logic [`LDP_DUTY_W:0] next_duty = analog_dimming_enable ?
    prod[`LDP_DUTY_W+`LDP_ANA_W:`LDP_ANA_W] : pwm_duty;

  // period generation
  logic [`LDP_PRESC_W-1:0] presc, tick_div;
  logic [`LDP_DUTY_W-1:0]  period_count;
  logic                    resync;
  wire logic tick = (presc == '0);
  wire logic period_start = tick && (period_count == `LDP_CNT_MAX);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      presc        <= '0;
      period_count <= `LDP_CNT_ZERO;
    end else if (resync) begin
      presc        <= tick_div;
      period_count <= `LDP_CNT_ZERO;
    end else begin
      presc <= tick ? tick_div : presc - 1'b1;
      if (tick) period_count <= period_count + 1'b1;
    end
  end

  // frame sync: measure frame period, derive tick spacing
  logic [`LDP_MEAS_W-1:0] frame_cnt, frame_len;
  wire logic frame_rise = frame_s & ~frame_d;
  wire logic frame_ok = (frame_cnt >= 20'(`LDP_FRAME_MIN_CYC)) &&
                        (frame_cnt <= 20'(`LDP_FRAME_MAX_CYC));
  // same output rate for any detected frame rate that is a whole multiple of 30Hz: scale the frame period up
  // by the rate ratio to a 30Hz base, then divide by the selected multiple;
  // the quarter-period bias absorbs a count or two of frame jitter
  wire logic [`LDP_MEAS_W-1:0] frame_bias = frame_len >> 2;
  wire logic [`LDP_MEAS_W-1:0] frame_ratio = (frame_len == '0) ? 20'h1 :
    (20'(`LDP_FRAME_MAX_CYC) + frame_bias) / frame_len;
  wire logic [`LDP_MEAS_W-1:0] frame_mult = 20'(frame_len * frame_ratio);
  wire logic [`LDP_MEAS_W-1:0] sync_div =
    (frame_mult >> `LDP_DUTY_W) / ({14'h0, freq_select} + 20'h1);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_d      <= 1'b0;
      frame_cnt    <= '0;
      frame_len    <= '0;
      frame_locked <= 1'b0;
    end else begin
      frame_d <= frame_s;
      if (frame_rise) begin
        frame_cnt    <= '0;
        frame_locked <= frame_ok;
        if (frame_ok) frame_len <= frame_cnt;
      end else if (!(&frame_cnt)) begin
        frame_cnt <= frame_cnt + 1'b1;
      end else begin
        frame_locked <= 1'b0;
      end
    end
  end
  always_comb begin
    resync = 1'b0;
    tick_div = free_run_divider;
    case (mode)
      ldp_pkg::ldp_frame_sync: begin
        tick_div = (frame_locked && sync_div != '0) ?
          sync_div[`LDP_PRESC_W-1:0] : free_run_divider;
        resync = frame_rise && frame_ok;
      end
      ldp_pkg::ldp_free_run: resync = 1'b0;
      ldp_pkg::ldp_direct:   resync = 1'b0;
      default:               resync = 1'b0;
    endcase
  end

  // duty and level take effect only at period boundaries; direct mode passes level straight through
  logic level_latched;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_duty   <= '0;
      level_latched <= 1'b0;
    end else if (period_start || resync) begin
      active_duty   <= next_duty;
      level_latched <= current_level_select;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) use_second_current_set <= 1'b0;
    else use_second_current_set <= is_direct ? current_level_select :
                                   level_latched;
  end

  // channel gates
  logic [`LDP_CHANNELS-1:0] gen_on;
  genvar ch;
  generate
    for (ch = 0; ch < `LDP_CHANNELS; ch++) begin : g_ch
      wire logic [`LDP_DUTY_W-1:0] ch_off = phase_shift_enable ?
        `LDP_DUTY_W'(ch * `LDP_QUARTER) : `LDP_CNT_ZERO;
      ldp_channel u_ch (
        .core_clk     (core_clk),
        .reset        (reset),
        .period_count (period_count),
        .offset       (ch_off),
        .duty         (active_duty),
        .gate_on      (gen_on[ch])
      );
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (reset) led_channel_enable <= '0;
    else if (is_direct) led_channel_enable <= {`LDP_CHANNELS{pwm_s}};
    else led_channel_enable <= gen_on;
  end

  // headroom: lowest channel voltage
  logic [`LDP_VOLT_W-1:0] min_v;
  logic [1:0]             min_i;
  always_comb begin
    min_v = led_channel_voltage[`LDP_VOLT_W-1:0];
    min_i = 2'h0;
    for (int i = 1; i < `LDP_CHANNELS; i++) begin
      if (led_channel_voltage[i*`LDP_VOLT_W +: `LDP_VOLT_W] < min_v) begin
        min_v = led_channel_voltage[i*`LDP_VOLT_W +: `LDP_VOLT_W];
        min_i = 2'(i);
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      headroom_min_voltage <= '0;
      headroom_min_channel <= 2'h0;
    end else begin
      headroom_min_voltage <= min_v;
      headroom_min_channel <= min_i;
    end
  end
endmodule

// ==== tb/ldp_dimming_assertions.sv ====
// assertion checker for the dimming block
module ldp_dimming_assertions (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        direct_mode_tie,
  input wire logic        phase_shift_enable,
  input wire logic        current_level_select,
  input wire logic        dimming_pwm_input,
  input wire logic [31:0] led_channel_voltage,
  input wire logic [3:0]  led_channel_enable,
  input wire logic        use_second_current_set,
  input wire logic [7:0]  headroom_min_voltage,
  input wire logic [1:0]  headroom_min_channel,
  input wire logic [10:0] active_duty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] vmin;
  always_comb begin
    vmin = led_channel_voltage[7:0];
    for (int i = 1; i < 4; i++) begin
      if (led_channel_voltage[8*i+:8] < vmin) vmin = led_channel_voltage[8*i+:8];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // six cycles of tie cover the pin synchroniser
  sequence s_tie;
    direct_mode_tie [*6];
  endsequence
  property p_direct_on;
    s_tie ##0 (direct_mode_tie && dimming_pwm_input) [*2] |-> ##3 led_channel_enable == 4'hF;
  endproperty
  property p_direct_off;
    s_tie ##0 (direct_mode_tie && !dimming_pwm_input) [*2] |-> ##3 led_channel_enable == 4'h0;
  endproperty
  property p_level_second;
    (direct_mode_tie && current_level_select) [*6] |-> use_second_current_set;
  endproperty
  property p_level_first;
    (direct_mode_tie && !current_level_select) [*6] |-> !use_second_current_set;
  endproperty
  property p_gang;
    !phase_shift_enable [*4] |-> led_channel_enable inside {4'h0, 4'hF};
  endproperty
  property p_stagger;
    $rose(led_channel_enable[0]) && phase_shift_enable && !direct_mode_tie |->
      (phase_shift_enable && !direct_mode_tie) throughout (##256 $rose(led_channel_enable[1]));
  endproperty
  // the edge that releases reset still loads zeros, so skip it
  property p_head_min;
    !$past(reset) |-> headroom_min_voltage == $past(vmin);
  endproperty
  property p_head_chan;
    !$past(reset) |->
      headroom_min_voltage == 8'($past(led_channel_voltage) >> (8 * headroom_min_channel));
  endproperty
  property p_duty_max;
    active_duty <= 11'h400;
  endproperty
  a_direct_on: assert property (p_direct_on) else $error("direct gates not on");
  a_direct_off: assert property (p_direct_off) else $error("direct gates not off");
  a_level_second: assert property (p_level_second) else $error("level not second");
  a_level_first: assert property (p_level_first) else $error("level not first");
  a_gang: assert property (p_gang) else $error("channels not ganged");
  a_stagger: assert property (p_stagger) else $error("phase step wrong");
  a_head_min: assert property (p_head_min) else $error("minimum wrong");
  a_head_chan: assert property (p_head_chan) else $error("minimum channel wrong");
  a_duty_max: assert property (p_duty_max) else $error("duty above full");
endmodule

bind ldp_dimming ldp_dimming_assertions i_ldp_dimming_assertions (
  .core_clk, .reset, .direct_mode_tie, .phase_shift_enable, .current_level_select,
  .dimming_pwm_input, .led_channel_voltage, .led_channel_enable, .use_second_current_set,
  .headroom_min_voltage, .headroom_min_channel, .active_duty
);

// ==== tb/ldp_tcon_model.sv ====
// timing controller model driving the dimming input
module ldp_tcon_model (
  input  wire logic        core_clk,
  input  wire logic [10:0] period,
  input  wire logic [10:0] high,
  output logic             dimming_pwm_input
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] cnt = 11'h000;
  initial dimming_pwm_input = 1'b0;
  // free counter, so the duty is exact at any phase
  always @(posedge core_clk) begin
    cnt <= (cnt + 11'h001 >= period) ? 11'h000 : cnt + 11'h001;
    dimming_pwm_input <= (cnt < high);
  end
endmodule

// ==== tb/led_dimming_pwm_control_tb.sv ====
// self-checking bench for the dimming block
module led_dimming_pwm_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        direct_mode_tie = 1'b0;
  logic        phase_shift_enable = 1'b0;
  logic        current_level_select = 1'b0;
  logic        analog_dimming_enable = 1'b0;
  logic        frame_sync_enable = 1'b0;
  logic        frame_sync_input = 1'b0;
  logic [7:0]  analog_dimming_input = 8'h00;
  logic [31:0] led_channel_voltage = 32'h40229031;
  logic [10:0] period = 11'h040;
  logic [10:0] high = 11'h010;
  logic        dimming_pwm_input;
  logic [3:0]  led_channel_enable;
  logic        use_second_current_set;
  logic [7:0]  headroom_min_voltage;
  logic [1:0]  headroom_min_channel;
  logic [10:0] active_duty;
  logic        frame_locked;
  logic [7:0]  codes [4] = '{8'h54, 8'h0F, 8'h99, 8'h54};
  logic [10:0] exps [4] = '{11'h100, 11'h000, 11'h200, 11'h200};
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  ldp_tcon_model i_ldp_tcon_model (.core_clk, .period, .high, .dimming_pwm_input);
  ldp_dimming i_ldp_dimming (
    .core_clk, .reset, .direct_mode_tie, .frame_sync_enable, .phase_shift_enable,
    .current_level_select, .dimming_pwm_input, .analog_dimming_enable, .analog_dimming_input,
    .frame_sync_input, .freq_select(6'h00), .free_run_divider(16'h0000),
    .led_channel_voltage, .led_channel_enable, .use_second_current_set, .headroom_min_voltage,
    .headroom_min_channel, .frame_locked, .active_duty
  );
  initial forever #25 core_clk = ~core_clk;
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rise(input int b);
    @(posedge core_clk iff led_channel_enable[b] === 1'b0);
    @(posedge core_clk iff led_channel_enable[b] === 1'b1);
  endtask
  // three periods: one to decode, one to latch, one spare
  task automatic run_duty(input logic [10:0] h, input logic ae, input logic [7:0] code,
                          input logic [10:0] exp);
    high <= h;
    analog_dimming_enable <= ae;
    analog_dimming_input <= code;
    repeat (3200) @(posedge core_clk);
    check(active_duty, exp);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    // frame lock needs one full 300Hz frame, about 67k cycles
    if (cycles == 80000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    int n;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    direct_mode_tie <= 1'b1;
    current_level_select <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(headroom_min_voltage, 11'h022);
    check(headroom_min_channel, 11'h002);
    led_channel_voltage <= 32'h157FA0C0;
    repeat (2) @(posedge core_clk);
    check(headroom_min_voltage, 11'h015);
    check(headroom_min_channel, 11'h003);
    // a frame edge this soon after reset is far too fast to lock
    frame_sync_input <= 1'b1;
    repeat (4) @(posedge core_clk);
    frame_sync_input <= 1'b0;
    repeat (16) @(posedge core_clk);
    check(frame_locked, 11'h000);
    @(posedge core_clk iff dimming_pwm_input === 1'b1);
    repeat (6) @(posedge core_clk);
    check(led_channel_enable, 11'h00F);
    check(use_second_current_set, 11'h001);
    @(posedge core_clk iff dimming_pwm_input === 1'b0);
    repeat (6) @(posedge core_clk);
    check(led_channel_enable, 11'h000);
    $display("direct mode test done");
    direct_mode_tie <= 1'b0;
    current_level_select <= 1'b0;
    period <= 11'h400;
    run_duty(11'h100, 1'b0, 8'h00, 11'h100);
    wait_rise(0);
    n = 0;
    while (led_channel_enable[0] === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    check(11'(n), 11'h100);
    wait_rise(0);
    current_level_select <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(use_second_current_set, 11'h000);
    wait_rise(0);
    repeat (3) @(posedge core_clk);
    check(use_second_current_set, 11'h001);
    $display("free run test done");
    for (int i = 0; i < 4; i++) begin
      run_duty(11'h200, i < 3, codes[i], exps[i]);
    end
    $display("analog test done");
    phase_shift_enable <= 1'b1;
    run_duty(11'h100, 1'b0, 8'h00, 11'h100);
    for (int b = 1; b < 4; b++) begin
      wait_rise(0);
      n = 0;
      while (led_channel_enable[b] !== 1'b1 && n < 2000) begin
        @(posedge core_clk);
        n++;
      end
      check(11'(n), 11'(256 * b));
    end
    phase_shift_enable <= 1'b0;
    $display("phase shift test done");
    frame_sync_enable <= 1'b1;
    @(posedge core_clk iff cycles >= 68000);
    wait_rise(0);
    repeat (300) @(posedge core_clk);
    check(led_channel_enable, 11'h000);
    frame_sync_input <= 1'b1;
    repeat (4) @(posedge core_clk);
    frame_sync_input <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(frame_locked, 11'h001);
    check(led_channel_enable, 11'h00F);
    $display("frame sync test done");
    final_report();
  end
endmodule
